// [common/nvb_pkg.sv]
package nvb_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int unsigned DEPTH      = 32;
  localparam int unsigned INDEX_W    = 5;
  localparam int unsigned DATA_W     = 8;

  // ------------------------------------------------------------
  // register decode (data memory bank and address)
  // ------------------------------------------------------------
  localparam logic [7:0] INDEX_ADDR  = 8'h1e;
  localparam logic [7:0] BYTE_ADDR   = 8'h1f;
  localparam logic [7:0] CTRL_ADDR   = 8'h40;
  localparam logic [7:0] CTRL_BANK   = 8'h01;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int unsigned FETCH_GO_BIT   = 0;
  localparam int unsigned FETCH_EN_BIT   = 1;
  localparam int unsigned PROG_GO_BIT    = 2;
  localparam int unsigned PROG_EN_BIT    = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_RESET  = 4'h0;
  localparam logic [4:0] INDEX_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ   = 10_000_000;
  localparam int unsigned SLOW_RC_HZ   = 32_000;
  localparam int unsigned SLOW_DIV     = SYS_CLK_HZ / SLOW_RC_HZ;
  localparam int unsigned WRITE_TICKS  = 64;
  localparam int unsigned READ_CYCLES  = 2;

  // ------------------------------------------------------------
  // resolved data memory access from the core
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       indirect;
    logic [7:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvb_access_t;

  typedef enum logic [1:0] {
    NVB_IDLE  = 2'b00,
    NVB_FETCH = 2'b01,
    NVB_PROG  = 2'b10
  } nvb_state_t;

endpackage

// [testbench/nvb_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module nvb_core_model (
  input  wire logic            i_sys_clk,
  input  wire logic [7:0]      i_rdata,
  output nvb_pkg::nvb_access_t o_acc,
  output logic                 o_gie
);
  initial o_acc = '0;
  initial o_gie = 1'b0;
  // one instruction: set after an edge, taken at the next; released fields show junk
  task automatic acc(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_sys_clk);
    o_acc <= '{w, !w, ind, {7'h00, ind}, a, d};
    @(posedge i_sys_clk);
    o_acc <= '{1'b0, 1'b0, !ind, 8'hfe, ~a, ~d};
    #1 q = i_rdata;
  endtask
  // write sequence: index, byte, enable, then go in the next instruction
  task automatic store(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    o_gie <= 1'b0;
    acc(1'b1, 1'b0, nvb_pkg::INDEX_ADDR, a, q);
    acc(1'b1, 1'b0, nvb_pkg::BYTE_ADDR, d, q);
    acc(1'b1, 1'b1, nvb_pkg::CTRL_ADDR, 8'h08, q);
    acc(1'b1, 1'b1, nvb_pkg::CTRL_ADDR, 8'h0c, q);
    o_gie <= 1'b1;
  endtask
  // read sequence: enable first, then index, then go with enable kept set
  task automatic fetch(input logic [7:0] a);
    logic [7:0] q;
    acc(1'b1, 1'b1, nvb_pkg::CTRL_ADDR, 8'h02, q);
    acc(1'b1, 1'b0, nvb_pkg::INDEX_ADDR, a, q);
    acc(1'b1, 1'b1, nvb_pkg::CTRL_ADDR, 8'h03, q);
  endtask
  // poll control until the go bits in m clear, touching nothing else
  task automatic settle(input logic [7:0] m, output logic ok);
    logic [7:0] q;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      acc(1'b0, 1'b1, nvb_pkg::CTRL_ADDR, 8'h00, q);
      ok = (q & m) == 8'h00;
    end
  endtask
endmodule
`default_nettype wire

// [testbench/nvb_props.sv]
`timescale 1ns/1ps
`default_nettype none
module nvb_props #(
  parameter int unsigned SLOW_DIV    = 4,
  parameter int unsigned WRITE_TICKS = 3
) (
  input wire logic                 i_sys_clk,
  input wire logic                 i_sys_rst,
  input wire nvb_pkg::nvb_access_t i_access,
  input wire logic [7:0]           o_rdata,
  input wire logic                 i_done_irq_enable,
  input wire logic                 i_global_irq_enable,
  input wire logic                 i_stack_full,
  input wire logic                 i_irq_serviced,
  input wire logic                 o_done_irq_flag,
  input wire logic                 o_irq_request,
  input wire logic                 o_busy
);
  localparam int W_MAX = SLOW_DIV * (WRITE_TICKS + 1) + 4;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // --------------------------------------------------
  // control writes that may start a cycle
  // --------------------------------------------------
  sequence s_ctrl_wr(v);
    i_access.wr && i_access.indirect && i_access.bank == 8'h01 && i_access.addr == 8'h40
      && i_access.wdata == v && !o_busy;
  endsequence
  sequence s_fetch_go;
    s_ctrl_wr(8'h03) ##1 o_busy;
  endsequence
  sequence s_prog_go;
    s_ctrl_wr(8'h0c) ##1 o_busy;
  endsequence
  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  a_fetch_len_fixed: assert property (s_fetch_go |-> ##1 o_busy ##1 !o_busy)
    else $error("fetch cycle length wrong");
  a_prog_len_bound: assert property (s_prog_go |-> o_busy[*8] ##[1:W_MAX] !o_busy)
    else $error("write cycle length out of range");
  a_flag_after_write: assert property ($rose(o_done_irq_flag) |-> $past(o_busy) || $past(o_busy, 2))
    else $error("done flag rose without a write ending");
  a_flag_clear_cause: assert property ($fell(o_done_irq_flag) |-> $past(i_irq_serviced))
    else $error("done flag fell without service");
  a_both_go_refused: assert property (i_access.wr && i_access.indirect && i_access.bank == 8'h01
    && i_access.addr == 8'h40 && i_access.wdata[0] && i_access.wdata[2] && !o_busy |=> !o_busy)
    else $error("both go bits together started a cycle");
  a_irq_req_gate: assert property (o_irq_request == (o_done_irq_flag && i_done_irq_enable
    && i_global_irq_enable && !i_stack_full))
    else $error("interrupt request gating wrong");
  a_index_upper_zero: assert property (i_access.rd && i_access.addr == 8'h1e |=> o_rdata[7:5] == 3'h0)
    else $error("index upper bits not zero");
  a_ctrl_hidden_direct: assert property (i_access.rd && i_access.addr == 8'h40 && !i_access.indirect
    |=> o_rdata == 8'h00)
    else $error("control visible by direct access");
  a_reset_clears_all: assert property (disable iff (1'b0) i_sys_rst |=> !o_busy && !o_done_irq_flag
    && o_rdata == 8'h00)
    else $error("reset left state set");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic                 clk, rst, ie, sf, svc, gie, flag, irq, busy, ok;
  logic [7:0]           rdata, q;
  nvb_pkg::nvb_access_t acc;
  int                   n_fail, cmp_count, cyc;
  localparam logic [7:0] IX = nvb_pkg::INDEX_ADDR, BY = nvb_pkg::BYTE_ADDR, CT = nvb_pkg::CTRL_ADDR;
  nvb_data_store #(.SLOW_DIV(4), .WRITE_TICKS(3), .READ_CYCLES(2)) dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_access(acc), .o_rdata(rdata), .i_done_irq_enable(ie),
    .i_global_irq_enable(gie), .i_stack_full(sf), .i_irq_serviced(svc), .o_done_irq_flag(flag),
    .o_irq_request(irq), .o_busy(busy));
  nvb_core_model core (.i_sys_clk(clk), .i_rdata(rdata), .o_acc(acc), .o_gie(gie));
  // clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.acc(1'b1, a == CT, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    core.acc(1'b0, a == CT, a, 8'h00, q);
    `CHK(q, e)
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset();
    rd(IX, 8'h00);
    rd(BY, 8'h00);
    rd(CT, 8'h00);
    `CHK({busy, flag}, 2'b00)
  endtask
  task automatic t_regs();
    wr(IX, 8'hff);
    rd(IX, 8'h1f);
    wr(BY, 8'ha5);
    rd(BY, 8'ha5);
    core.acc(1'b1, 1'b0, CT, 8'h08, q);
    rd(CT, 8'h00);
    core.acc(1'b0, 1'b0, CT, 8'h00, q);
    `CHK(q, 8'h00)
  endtask
  task automatic t_write(input logic [7:0] a, input logic [7:0] d);
    core.store(a, d);
    rd(CT, 8'h0c);
    core.settle(8'h04, ok);
    `CHK(ok, 1'b1)
    rd(CT, 8'h08);
    `CHK(flag, 1'b1)
    wr(CT, 8'h00);
  endtask
  task automatic t_irq();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ie <= i[0];
      core.o_gie <= i[1];
      sf <= i[2];
      @(posedge clk) #1;
      `CHK(irq, i[0] & i[1] & !i[2])
    end
    @(posedge clk) svc <= 1'b1;
    @(posedge clk) svc <= 1'b0;
    #1 `CHK({flag, irq}, 2'b00)
  endtask
  task automatic t_read(input logic [7:0] a, input logic [7:0] e);
    core.fetch(a);
    core.settle(8'h01, ok);
    `CHK(ok, 1'b1)
    rd(BY, e);
    wr(IX, a ^ 8'h01);
    rd(BY, e);
    wr(CT, 8'h00);
  endtask
  task automatic t_refuse();
    wr(IX, 8'h05);
    wr(BY, 8'h99);
    wr(CT, 8'h04);
    rd(CT, 8'h00);
    `CHK(busy, 1'b0)
    wr(CT, 8'h01);
    rd(CT, 8'h00);
    rd(BY, 8'h99);
    wr(CT, 8'h0a);
    wr(CT, 8'h0f);
    rd(CT, 8'h0a);
    wr(CT, 8'h00);
    t_read(8'h05, 8'h3c);
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst = 1'b1;
    ie = 1'b0;
    sf = 1'b0;
    svc = 1'b0;
    do_reset();
    t_reset();
    t_regs();
    t_write(8'h05, 8'h3c);
    t_irq();
    t_write(8'h1f, 8'hc3);
    t_read(8'h05, 8'h3c);
    t_read(8'h1f, 8'hc3);
    t_refuse();
    do_reset();
    t_reset();
    complete_run();
  end
endmodule
bind nvb_data_store nvb_props #(.SLOW_DIV(SLOW_DIV), .WRITE_TICKS(WRITE_TICKS)) u_props (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_access(i_access), .o_rdata(o_rdata),
  .i_done_irq_enable(i_done_irq_enable), .i_global_irq_enable(i_global_irq_enable),
  .i_stack_full(i_stack_full), .i_irq_serviced(i_irq_serviced), .o_done_irq_flag(o_done_irq_flag),
  .o_irq_request(o_irq_request), .o_busy(o_busy));
`default_nettype wire

// [verilog/nvb_data_store.sv]
// Overview of operation
// - array of 32 bytes, reached one byte at a time via three registers
// - index register holds 5-bit location in bits 4..0, upper bits read zero
// - byte register is full 8-bit read/write data
// - control register sits at 40H of bank 1, indirect access only
// - program enable bit 3 clear means no write to the array
// - bit 2 starts a write only if enable already set; cleared when done
// - fetch enable bit 1 clear means no read from the array; checked only when bit 0 is written, so a read under way still completes
// - bit 0 starts a read only if enable already set; cleared when done
// - read result lands in byte register and stays until the next read or a software write to the byte register
// - write is timed by a slow free running timer, duration unspecified
// - reset clears control, index and byte registers
// - write end sets done flag; requests vector if enabled and stack free
// - done flag clears automatically when serviced
`timescale 1ns/1ps
`default_nettype none

module nvb_data_store #(
  parameter int unsigned DEPTH       = nvb_pkg::DEPTH,
  parameter int unsigned SLOW_DIV    = nvb_pkg::SLOW_DIV,
  parameter int unsigned WRITE_TICKS = nvb_pkg::WRITE_TICKS,
  parameter int unsigned READ_CYCLES = nvb_pkg::READ_CYCLES
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_sys_rst,
  input  wire nvb_pkg::nvb_access_t i_access,
  output logic [7:0]               o_rdata,
  input  wire logic                i_done_irq_enable,
  input  wire logic                i_global_irq_enable,
  input  wire logic                i_stack_full,
  input  wire logic                i_irq_serviced,
  output logic                     o_done_irq_flag,
  output logic                     o_irq_request,
  output logic                     o_busy
);

  localparam int unsigned RW = $clog2(READ_CYCLES + 1);

  // ------------------------------------------------------------
  // storage and registers
  // ------------------------------------------------------------
  logic [7:0]          mem_reg [DEPTH];
  logic [4:0]          nv_index_reg;
  logic [7:0]          nv_byte_reg;
  logic                program_enable;
  logic                prog_go;
  logic                fetch_enable;
  logic                fetch_go;
  logic [RW-1:0]       fetch_cnt_reg;
  nvb_pkg::nvb_state_t state_reg;
  nvb_pkg::nvb_state_t state_next;
  logic                prog_done;
  logic                prog_busy;
  logic                prog_start;
  logic                fetch_done;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic hit(input nvb_pkg::nvb_access_t a, input logic [7:0] addr);
    hit = (a.addr == addr);
  endfunction

  logic sel_index;
  logic sel_byte;
  logic sel_ctrl;
  logic wr_ctrl;
  logic ask_fetch;
  logic ask_prog;

  assign sel_index = hit(i_access, nvb_pkg::INDEX_ADDR);
  assign sel_byte  = hit(i_access, nvb_pkg::BYTE_ADDR);
  // control register only through the indirect port with bank one
  assign sel_ctrl  = hit(i_access, nvb_pkg::CTRL_ADDR) && i_access.indirect
                     && (i_access.bank == nvb_pkg::CTRL_BANK);
  assign wr_ctrl   = i_access.wr && sel_ctrl;

  // go only counts if its enable was already set; both go bits together are dropped
  assign ask_fetch = wr_ctrl && i_access.wdata[nvb_pkg::FETCH_GO_BIT] && fetch_enable
                     && !i_access.wdata[nvb_pkg::PROG_GO_BIT];
  assign ask_prog  = wr_ctrl && i_access.wdata[nvb_pkg::PROG_GO_BIT] && program_enable
                     && !i_access.wdata[nvb_pkg::FETCH_GO_BIT];

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nvb_pkg::NVB_IDLE: begin
        if (ask_prog) begin
          state_next = nvb_pkg::NVB_PROG;
        end else if (ask_fetch) begin
          state_next = nvb_pkg::NVB_FETCH;
        end
      end
      nvb_pkg::NVB_FETCH: begin
        if (fetch_done) begin
          state_next = nvb_pkg::NVB_IDLE;
        end
      end
      nvb_pkg::NVB_PROG: begin
        if (prog_done) begin
          state_next = nvb_pkg::NVB_IDLE;
        end
      end
      default: begin
        state_next = nvb_pkg::NVB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_reg <= nvb_pkg::NVB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // never restart the timer while it is still counting out a cut cycle
  assign prog_start = (state_reg == nvb_pkg::NVB_IDLE) && ask_prog && !prog_busy;
  assign fetch_done = (state_reg == nvb_pkg::NVB_FETCH) && (fetch_cnt_reg == RW'(READ_CYCLES - 1));
  assign o_busy     = (state_reg != nvb_pkg::NVB_IDLE);

  // read cycle length counter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || state_reg != nvb_pkg::NVB_FETCH) begin
      fetch_cnt_reg <= '0;
    end else begin
      fetch_cnt_reg <= fetch_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // write cycle timer on the slow rate
  // ------------------------------------------------------------
  nvb_prog_timer #(
    .DIV   (SLOW_DIV),
    .TICKS (WRITE_TICKS)
  ) u_prog_timer (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (prog_start),
    .o_busy    (prog_busy),
    .o_done    (prog_done)
  );

  // ------------------------------------------------------------
  // control register: enables and self clearing go bits
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      {program_enable, prog_go, fetch_enable, fetch_go} <= nvb_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        program_enable <= i_access.wdata[nvb_pkg::PROG_EN_BIT];
        fetch_enable   <= i_access.wdata[nvb_pkg::FETCH_EN_BIT];
      end
      if (prog_done) begin
        prog_go <= 1'b0;
      end else if (prog_start) begin
        prog_go <= 1'b1;
      end
      if (fetch_done) begin
        fetch_go <= 1'b0;
      end else if ((state_reg == nvb_pkg::NVB_IDLE) && ask_fetch && !ask_prog) begin
        fetch_go <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // index register
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      nv_index_reg <= nvb_pkg::INDEX_RESET;
    end else if (i_access.wr && sel_index) begin
      nv_index_reg <= i_access.wdata[4:0];
    end
  end

  // ------------------------------------------------------------
  // byte register: software data, replaced by fetched data
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      nv_byte_reg <= nvb_pkg::BYTE_RESET;
    end else if (fetch_done) begin
      nv_byte_reg <= mem_reg[nv_index_reg];
    end else if (i_access.wr && sel_byte) begin
      nv_byte_reg <= i_access.wdata;
    end
  end

  // ------------------------------------------------------------
  // nonvolatile array: committed at write end if still enabled
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (prog_done && program_enable) begin
      mem_reg[nv_index_reg] <= nv_byte_reg;
    end
  end

  // ------------------------------------------------------------
  // write done flag and vector request
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_done_irq_flag <= 1'b0;
    end else if (prog_done) begin
      o_done_irq_flag <= 1'b1;                   // set wins over service
    end else if (i_irq_serviced) begin
      o_done_irq_flag <= 1'b0;
    end
  end

  assign o_irq_request = o_done_irq_flag && i_done_irq_enable
                         && i_global_irq_enable && !i_stack_full;

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_access.rd) begin
      if (sel_index) begin
        o_rdata <= {3'h0, nv_index_reg};
      end else if (sel_byte) begin
        o_rdata <= nv_byte_reg;
      end else if (sel_ctrl) begin
        o_rdata <= {4'h0, program_enable, prog_go, fetch_enable, fetch_go};
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/nvb_prog_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module nvb_prog_timer #(
  parameter int unsigned DIV   = nvb_pkg::SLOW_DIV,
  parameter int unsigned TICKS = nvb_pkg::WRITE_TICKS
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  localparam int unsigned DW = $clog2(DIV + 1);
  localparam int unsigned TW = $clog2(TICKS + 1);

  logic [DW-1:0] div_reg;
  logic [TW-1:0] tick_reg;
  logic          slow_tick;

  // ------------------------------------------------------------
  // slow rc rate as a free running enable pulse
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || div_reg == DW'(DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign slow_tick = (div_reg == DW'(DIV - 1));

  // count slow ticks; start phase is unrelated to the tick, as with a free rc
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tick_reg <= '0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy   <= 1'b1;
        tick_reg <= '0;
      end else if (o_busy && slow_tick) begin
        if (tick_reg == TW'(TICKS - 1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;                       // one cycle completion pulse
        end else begin
          tick_reg <= tick_reg + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire
